// File: logic/uald_top.sv
// uald_top: low-power request and dma transfer requests of a serial
// port, with an apb register slave.
// assumes fifo levels, push/pop pulses and line levels from the core,
// all synchronous to CLK_SYS.
`timescale 1ns/100ps
// Summary of operation
// (R1) sleep after one idle character time
// (R2) idle: inputs high, out high, ir out low
// (R3) no sleep in loopback, fifo access, break
// (R4) character time is bits times sixteen ticks
// (R5) wake on input low, write, modem change
// (R6) wake clears request without a clock
// (R7) gating logic may synchronise the request
// (R8) reads never wake; clock needed to read
// (R9) serial clock back within five baud clocks
// (R10) ir mode: clocks back within three clocks
// (R11) two clocks: bus clock within 112 cycles
// (R12) tx request after reset follows build option
// (R13) dma mode bit three, mode 0 without fifo
// (R14) mode 0 tx asserts when empty enough
// (R15) mode 0 tx releases when filled
// (R16) mode 0 rx follows any data present
// (R17) mode 1 tx holds until fifo full
// (R18) mode 1 rx on trigger or timeout
// (R19) handshake option raises like mode 0; rx with fifo on waits for the rx trigger level
// (R20) handshake option drops only on ack
// (R21) handshake option ignores dma mode bit
// (R22) controller uses byte transfer width
// (R23) no new request until ack released
// (R24) tx threshold from bits five to four
// (R25) rx trigger from bits seven to six
// (R26) timeout after four silent character times
// (R27) all timing from the bus clock
module uald_top
#(
   parameter bit FIFO_PRESENT = 1'b1,
   parameter bit DMA_ACK_HANDSHAKE = 1'b0,
   parameter bit TX_REQUEST_AT_RESET_PARAM = 1'b1
)
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // core fifo state
   input wire uald_pkg::uald_level_type TX_LEVEL,
   input wire uald_pkg::uald_level_type RX_LEVEL,
   input wire logic RX_PUSH,
   input wire logic RX_POP,
   // serial and modem lines
   input wire logic SIN,
   input wire logic SIR_IN,
   input wire logic SOUT,
   input wire logic SIR_OUT_N,
   input wire logic [3:0] MODEM_IN,
   // dma handshake
   input wire logic DMA_TX_ACK_N,
   input wire logic DMA_RX_ACK_N,
   output logic DMA_TX_REQ_N,
   output logic DMA_RX_REQ_N,
   // clock gating request
   output logic LOWPOWER_REQ_BUSCLK
);
   import uald_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [7:0] fifo_control_reg_r;
   logic [7:0] line_control_reg_r;
   logic [7:0] mode_r;
   logic [15:0] divisor_r;
   logic soft_r;
   logic tx_arm_r;
   logic [15:0] baud_cnt_r;
   logic baud_tick;
   logic [3:0] modem_r;
   logic [2:0] to_cnt_r;
   logic timeout_r;
   logic setup;
   logic wr_en;
   logic wr_lcr;
   logic rst_any_n;
   logic mapped;
   logic [31:0] rd_data;
   logic fifo_on;
   logic tx_empty_level_mode_on;
   logic mode1;
   logic tx_low;
   logic tx_set;
   logic tx_clr;
   logic rx_avail;
   logic rx_set;
   logic tx_req;
   logic rx_req;
   logic modem_chg;
   logic wake;
   logic idle_ok;
   logic idle_done;
   logic to_done;
   logic to_clear;
   logic [3:0] char_bits;

   assign rst_any_n = RST_N && !soft_r;
   assign char_bits = uald_char_bits(line_control_reg_r);

   // ------------------------------------------------------------
   // apb slave: answer one cycle after setup
   // ------------------------------------------------------------
   assign setup = PSEL && !PENABLE;
   assign wr_en = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   assign wr_lcr = wr_en && PADDR == OFS_LINE_CTRL;

   // address decode
   always_comb
   begin
      mapped = PADDR[1:0] == 2'h0 && PADDR <= OFS_STATUS;
      rd_data = 32'h0000_0000;
      case (PADDR)
         OFS_FIFO_CTRL: rd_data[7:0] = fifo_control_reg_r;
         OFS_LINE_CTRL: rd_data[7:0] = line_control_reg_r;
         OFS_MODE: rd_data[7:0] = mode_r;
         OFS_DIVISOR: rd_data[15:0] = divisor_r;
         OFS_STATUS: rd_data[5:0] = {mode1, tx_arm_r, timeout_r,
            !DMA_RX_REQ_N, !DMA_TX_REQ_N, LOWPOWER_REQ_BUSCLK};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // ready, error and read data captured in setup
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end
      else
      begin
         PREADY <= setup;
         PSLVERR <= setup && !mapped;
         // (R8) a read changes no state
         PRDATA <= (setup && !PWRITE && mapped) ? rd_data : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   // software registers, cleared by either reset
   always_ff @(posedge CLK_SYS)
   begin
      if (!rst_any_n)
      begin
         fifo_control_reg_r <= FCR_RST;
         line_control_reg_r <= LCR_RST;
         mode_r <= MODE_RST;
         divisor_r <= DIV_RST;
      end
      else if (wr_en)
      begin
         case (PADDR)
            OFS_FIFO_CTRL: fifo_control_reg_r <= PWDATA[7:0];
            OFS_LINE_CTRL: line_control_reg_r <= PWDATA[7:0];
            OFS_MODE: mode_r <= PWDATA[7:0];
            OFS_DIVISOR: divisor_r <= PWDATA[15:0];
            default: fifo_control_reg_r <= fifo_control_reg_r;
         endcase
      end
   end

   // soft reset pulse from the soft_reset_reg
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
         soft_r <= 1'b0;
      else
         soft_r <= wr_en && PADDR == OFS_SOFT_RESET && PWDATA[SRR_RESET];
   end

   // (R12) tx request armed at reset by the build option, or by line control write
   always_ff @(posedge CLK_SYS)
   begin
      if (!rst_any_n)
         tx_arm_r <= TX_REQUEST_AT_RESET_PARAM;
      else if (wr_lcr)
         tx_arm_r <= 1'b1;
   end

   // ------------------------------------------------------------
   // baud tick and modem sampling
   // ------------------------------------------------------------
   // (R27) baud tick from the bus clock, divisor 0 acts as 1
   always_ff @(posedge CLK_SYS)
   begin
      if (!rst_any_n || baud_tick)
         baud_cnt_r <= 16'h0001;
      else
         baud_cnt_r <= baud_cnt_r + 16'h0001;
   end
   assign baud_tick = baud_cnt_r >= divisor_r;

   // last seen modem inputs
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
         modem_r <= 4'h0;
      else
         modem_r <= MODEM_IN;
   end
   assign modem_chg = MODEM_IN != modem_r;

   // ------------------------------------------------------------
   // low-power request
   // ------------------------------------------------------------
   // (R2) idle levels, (R3) excluded modes
   assign idle_ok = RX_LEVEL == '0 && TX_LEVEL == '0 && SIN && SIR_IN
      && SOUT && !SIR_OUT_N && !modem_chg && !(PSEL && PWRITE)
      && !mode_r[MODE_LOOPBACK] && !mode_r[MODE_FIFO_ACCESS]
      && !line_control_reg_r[LCR_BREAK];

   // (R5) wake events
   assign wake = !SIN || !SIR_IN || (PSEL && PWRITE) || modem_chg;

   // (R1) (R4) one idle character time before sleeping
   uald_char_timer u_idle_timer
   (
      .clk(CLK_SYS),
      .rst_n(rst_any_n),
      .clear(!idle_ok),
      .tick(baud_tick),
      .char_bits(char_bits),
      .done(idle_done)
   );

   // (R6) wake clears the request without a clock edge
   always_ff @(posedge CLK_SYS or posedge wake)
   begin
      if (wake)
         LOWPOWER_REQ_BUSCLK <= 1'b0;
      else if (!rst_any_n)
         LOWPOWER_REQ_BUSCLK <= 1'b0;
      else if (idle_done && idle_ok)
         LOWPOWER_REQ_BUSCLK <= 1'b1;
   end

   // ------------------------------------------------------------
   // character timeout
   // ------------------------------------------------------------
   assign to_clear = RX_PUSH || RX_POP || RX_LEVEL == '0;

   // (R26) four silent character times with data held
   uald_char_timer u_to_timer
   (
      .clk(CLK_SYS),
      .rst_n(rst_any_n),
      .clear(to_clear),
      .tick(baud_tick),
      .char_bits(char_bits),
      .done(to_done)
   );

   // counts character times up to the timeout
   always_ff @(posedge CLK_SYS)
   begin
      if (!rst_any_n || to_clear)
         to_cnt_r <= 3'h0;
      else if (to_done && to_cnt_r != CHAR_TIMEOUT)
         to_cnt_r <= to_cnt_r + 3'h1;
   end
   assign timeout_r = to_cnt_r == CHAR_TIMEOUT;

   // ------------------------------------------------------------
   // dma request conditions
   // ------------------------------------------------------------
   assign fifo_on = FIFO_PRESENT && fifo_control_reg_r[FCR_FIFO_EN];
   assign tx_empty_level_mode_on = fifo_on && mode_r[MODE_TX_EMPTY_LEVEL];
   // (R13) mode 1 only with fifo on; (R21) ignored with handshake
   assign mode1 = fifo_on && fifo_control_reg_r[FCR_DMA_MODE] && !DMA_ACK_HANDSHAKE;

   // (R24) (R14) transmit low enough
   assign tx_low = tx_empty_level_mode_on
      ? TX_LEVEL <= uald_tx_thresh(fifo_control_reg_r[FCR_TX_THR +: 2])
      : TX_LEVEL == '0;
   assign tx_set = tx_low && tx_arm_r;
   // (R15) mode 0 release, (R17) mode 1 holds until full
   assign tx_clr = mode1 ? TX_LEVEL == LVL_W'(FIFO_DEPTH) : !tx_low;

   assign rx_avail = RX_LEVEL != '0;

   // (R25) (R16) (R18) (R19) receive raise conditions
   always_comb
   begin
      if (DMA_ACK_HANDSHAKE && fifo_on)
         rx_set = RX_LEVEL >= uald_rx_trig(fifo_control_reg_r[FCR_RX_TRIG +: 2]);
      else if (mode1)
         rx_set = RX_LEVEL >= uald_rx_trig(fifo_control_reg_r[FCR_RX_TRIG +: 2])
            || (timeout_r && rx_avail);
      else
         rx_set = rx_avail;
   end

   // (R19) (R20) (R23) transmit request
   uald_ack_req #(.REQ_AT_RESET(TX_REQUEST_AT_RESET_PARAM)) u_tx_req
   (
      .clk(CLK_SYS),
      .rst_n(rst_any_n),
      .set(tx_set),
      .clr(tx_clr),
      .handshake(DMA_ACK_HANDSHAKE),
      .ack_n(DMA_TX_ACK_N),
      .req(tx_req)
   );

   // (R20) (R23) receive request
   uald_ack_req #(.REQ_AT_RESET(1'b0)) u_rx_req
   (
      .clk(CLK_SYS),
      .rst_n(rst_any_n),
      .set(rx_set),
      .clr(!rx_avail),
      .handshake(DMA_ACK_HANDSHAKE),
      .ack_n(DMA_RX_ACK_N),
      .req(rx_req)
   );

   // active-low request outputs
   always_ff @(posedge CLK_SYS)
   begin
      if (!rst_any_n)
      begin
         DMA_TX_REQ_N <= !TX_REQUEST_AT_RESET_PARAM;
         DMA_RX_REQ_N <= 1'b1;
      end
      else
      begin
         DMA_TX_REQ_N <= !tx_req;
         DMA_RX_REQ_N <= !rx_req;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_sleep_after_idle;
      @(posedge CLK_SYS) disable iff (!RST_N)
      $rose(LOWPOWER_REQ_BUSCLK) |-> $past(idle_done && idle_ok);
   endproperty
   a_sleep_after_idle: assert property (p_sleep_after_idle) // (R1)
      else $error("low-power request without idle character time");

   property p_no_sleep_modes;
      @(posedge CLK_SYS) disable iff (!RST_N)
      $rose(LOWPOWER_REQ_BUSCLK) |-> !$past(mode_r[MODE_LOOPBACK]
         || mode_r[MODE_FIFO_ACCESS] || line_control_reg_r[LCR_BREAK]);
   endproperty
   a_no_sleep_modes: assert property (p_no_sleep_modes) // (R3)
      else $error("low-power request in an excluded mode");

   property p_wake_input;
      @(posedge CLK_SYS) disable iff (!RST_N)
      (!SIN || !SIR_IN || modem_chg) |-> !LOWPOWER_REQ_BUSCLK;
   endproperty
   a_wake_input: assert property (p_wake_input) // (R5)
      else $error("low-power request held during wake event");

   property p_arm_cause;
      @(posedge CLK_SYS) disable iff (!RST_N)
      $rose(tx_arm_r) |-> $past(wr_lcr) || $past(soft_r);
   endproperty
   a_arm_cause: assert property (p_arm_cause) // (R12)
      else $error("tx request armed without line control write");

   property p_m0_tx;
      @(posedge CLK_SYS) disable iff (!RST_N)
      (!fifo_on && !DMA_ACK_HANDSHAKE && TX_LEVEL == '0 && tx_arm_r && !soft_r)[*3]
         |-> !DMA_TX_REQ_N;
   endproperty
   a_m0_tx: assert property (p_m0_tx) // (R14)
      else $error("mode 0 tx request missing while empty");

   property p_m0_rx;
      @(posedge CLK_SYS) disable iff (!RST_N)
      (!fifo_on && !DMA_ACK_HANDSHAKE && rx_avail && !soft_r)[*3] |-> !DMA_RX_REQ_N;
   endproperty
   a_m0_rx: assert property (p_m0_rx) // (R16)
      else $error("mode 0 rx request missing with data");

   property p_m1_tx_hold;
      @(posedge CLK_SYS) disable iff (!RST_N)
      (mode1 && TX_LEVEL != LVL_W'(FIFO_DEPTH) && !soft_r)[*2] ##0 !DMA_TX_REQ_N
         |=> !DMA_TX_REQ_N;
   endproperty
   a_m1_tx_hold: assert property (p_m1_tx_hold) // (R17)
      else $error("mode 1 tx request dropped before full");

   property p_m1_rx_timeout;
      @(posedge CLK_SYS) disable iff (!RST_N)
      (mode1 && timeout_r && rx_avail && !soft_r)[*3] |-> !DMA_RX_REQ_N;
   endproperty
   a_m1_rx_timeout: assert property (p_m1_rx_timeout) // (R18)
      else $error("mode 1 rx request missing on timeout");

   property p_ack_drop;
      @(posedge CLK_SYS) disable iff (!RST_N)
      (DMA_ACK_HANDSHAKE && !DMA_TX_ACK_N && !soft_r)[*3] |-> DMA_TX_REQ_N;
   endproperty
   a_ack_drop: assert property (p_ack_drop) // (R20)
      else $error("tx request held while ack asserted");

   property p_timeout_data;
      @(posedge CLK_SYS) disable iff (!RST_N)
      $rose(timeout_r) |-> $past(rx_avail && !RX_PUSH && !RX_POP);
   endproperty
   a_timeout_data: assert property (p_timeout_data) // (R26)
      else $error("timeout without held data");

endmodule

// File: logic/uald_pkg.sv
// uald_pkg: constants, types and decode helpers for the low-power
// request and dma request block.
// assumes a 16-entry fifo and characters of five to eight data bits.
package uald_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int FIFO_DEPTH = 16;
   localparam int LVL_W = 5;
   typedef logic [LVL_W-1:0] uald_level_type;
   typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_WAIT} uald_hs_state_type;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_FIFO_CTRL = 8'h00;
   localparam logic [7:0] OFS_LINE_CTRL = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_DIVISOR = 8'h0c;
   localparam logic [7:0] OFS_SOFT_RESET = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int FCR_FIFO_EN = 0;
   localparam int FCR_DMA_MODE = 3;
   localparam int FCR_TX_THR = 4;
   localparam int FCR_RX_TRIG = 6;
   localparam int LCR_DATA_LEN = 0;
   localparam int LCR_STOP = 2;
   localparam int LCR_PARITY = 3;
   localparam int LCR_BREAK = 6;
   localparam int MODE_TX_EMPTY_LEVEL = 0;
   localparam int MODE_LOOPBACK = 1;
   localparam int MODE_FIFO_ACCESS = 2;
   localparam int SRR_RESET = 0;

   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0] FCR_RST = 8'h00;
   localparam logic [7:0] LCR_RST = 8'h03;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [15:0] DIV_RST = 16'h0001;
   localparam logic [3:0] BAUD_PER_BIT_LAST = 4'hf;
   localparam logic [3:0] START_BITS = 4'h1;
   localparam logic [3:0] MIN_DATA_BITS = 4'h5;
   localparam logic [2:0] CHAR_TIMEOUT = 3'h4;

   // bits in one character: start, data, parity, stop
   function automatic logic [3:0] uald_char_bits(input logic [7:0] line_control_reg);
      logic [3:0] stop;
      stop = line_control_reg[LCR_STOP] ? 4'h2 : 4'h1;
      return START_BITS + MIN_DATA_BITS + {2'h0, line_control_reg[LCR_DATA_LEN +: 2]}
         + {3'h0, line_control_reg[LCR_PARITY]} + stop;
   endfunction

   // transmit empty threshold: empty, two, quarter, half
   function automatic uald_level_type uald_tx_thresh(input logic [1:0] sel);
      case (sel)
         2'h0: return '0;
         2'h1: return LVL_W'(2);
         2'h2: return LVL_W'(FIFO_DEPTH / 4);
         default: return LVL_W'(FIFO_DEPTH / 2);
      endcase
   endfunction

   // receive trigger: one, quarter, half, two less than full
   function automatic uald_level_type uald_rx_trig(input logic [1:0] sel);
      case (sel)
         2'h0: return LVL_W'(1);
         2'h1: return LVL_W'(FIFO_DEPTH / 4);
         2'h2: return LVL_W'(FIFO_DEPTH / 2);
         default: return LVL_W'(FIFO_DEPTH - 2);
      endcase
   endfunction

endpackage

// File: logic/uald_char_timer.sv
// uald_char_timer: counts one character time in baud ticks.
// assumes one tick per baud clock and a held bit count.
`timescale 1ns/100ps
module uald_char_timer
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic clear,
   input wire logic tick,
   input wire logic [3:0] char_bits,
   // result
   output logic done
);
   import uald_pkg::*;

   logic [3:0] sub_r;
   logic [3:0] bit_r;

   // ------------------------------------------------------------
   // sixteen ticks per bit, char_bits bits per character
   // ------------------------------------------------------------
   // (R4) bit and sub-bit counting
   always_ff @(posedge clk)
   begin
      if (!rst_n || clear)
      begin
         sub_r <= 4'h0;
         bit_r <= 4'h0;
      end
      else if (tick)
      begin
         sub_r <= sub_r + 4'h1;
         if (sub_r == BAUD_PER_BIT_LAST)
            bit_r <= (bit_r == char_bits - 4'h1) ? 4'h0 : bit_r + 4'h1;
      end
   end

   // one-cycle pulse at the end of each character time
   always_ff @(posedge clk)
   begin
      if (!rst_n || clear)
         done <= 1'b0;
      else
         done <= tick && sub_r == BAUD_PER_BIT_LAST && bit_r == char_bits - 4'h1;
   end

endmodule

// File: logic/uald_ack_req.sv
// uald_ack_req: one dma request, level driven or ack handshaked.
// assumes set and clr are steady decodes of fifo state.
`timescale 1ns/100ps
module uald_ack_req
#(
   parameter bit REQ_AT_RESET = 1'b0
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // conditions
   input wire logic set,
   input wire logic clr,
   input wire logic handshake,
   input wire logic ack_n,
   // request, active high
   output logic req
);
   import uald_pkg::*;

   uald_hs_state_type state_r;
   uald_hs_state_type state_nxt;

   // next state: ack drops and blocks the request in handshake mode
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         HS_IDLE:
            if (set && (!handshake || ack_n))
               state_nxt = HS_REQ;
         HS_REQ:
            // (R20) drop only on ack
            if (handshake)
            begin
               if (!ack_n)
                  state_nxt = HS_WAIT;
            end
            else if (clr)
               state_nxt = HS_IDLE;
         HS_WAIT:
            // (R23) hold off until ack released
            if (ack_n)
               state_nxt = HS_IDLE;
         default:
            state_nxt = HS_IDLE;
      endcase
   end

   // state register, reset value follows the build option
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         state_r <= REQ_AT_RESET ? HS_REQ : HS_IDLE;
      else
         state_r <= state_nxt;
   end

   assign req = (state_r == HS_REQ);

endmodule

// File: verification/uald_dma_model.sv
// uald_dma_model: one dma channel and the clock gate stand-in.
// assumes active-low request and ack on one clock, reset active low.
`timescale 1ns/100ps
module uald_dma_model
#(
   parameter int ACK_DLY = 3
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // from the block
   input wire logic req_n,
   input wire logic lp_req,
   // answers
   output logic ack_n,
   output logic lp_sync
);
   int cnt;
   logic lp_meta;

   // ack after a delay, hold until request drops
   always_ff @(posedge clk)
   begin
      if (!rst_n || req_n)
      begin
         cnt <= 0;
         ack_n <= 1'b1;
      end
      else if (cnt == ACK_DLY)
         ack_n <= 1'b0;
      else
         cnt <= cnt + 1;
   end

   // clock never gated here, back at once
   // two-flop sync before the gate latch
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         {lp_sync, lp_meta} <= 2'h0;
      else
         {lp_sync, lp_meta} <= {lp_meta, lp_req};
   end
endmodule

// File: verification/testbench.sv
// testbench: random and corner checks of dma and low-power requests.
// assumes the default build for DUT: fifo present, no ack handshake.
`timescale 1ns/100ps
module testbench;
   import uald_pkg::*;
   logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er, m;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, sin = 1, sir_in = 1, sout = 1, sir_out_n = 0;
   uald_level_type tx_level = '0, rx_level = '0;
   logic [3:0] modem_in = '0;
   logic [1:0] s;
   logic tx_ack_n, rx_ack_n, tx_req_n, rx_req_n, lp_req, lp_sync, rx_push = 0;
   logic hs_tx_ack_n, hs_rx_ack_n, hs_tx_req_n, hs_rx_req_n, rx_pop = 0;
   int bad_count = 0, comparisons = 0, cycles = 0, n, t, r;
   uald_level_type txl [5] = '{5'h00, 5'h09, 5'h10, 5'h05, 5'h00};
   uald_level_type rxl [5] = '{5'h03, 5'h04, 5'h01, 5'h00, 5'h02};
   logic [4:0] txe = 5'h0c, rxe = 5'h19;

   uald_top DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .TX_LEVEL(tx_level), .RX_LEVEL(rx_level), .RX_PUSH(rx_push),
      .RX_POP(rx_pop), .SIN(sin), .SIR_IN(sir_in), .SOUT(sout), .SIR_OUT_N(sir_out_n),
      .MODEM_IN(modem_in), .DMA_TX_ACK_N(tx_ack_n), .DMA_RX_ACK_N(rx_ack_n),
      .DMA_TX_REQ_N(tx_req_n), .DMA_RX_REQ_N(rx_req_n), .LOWPOWER_REQ_BUSCLK(lp_req));
   uald_dma_model #(.ACK_DLY(1)) u_tx (.clk(clk_sys), .rst_n(rst_n), .req_n(tx_req_n),
      .lp_req(lp_req), .ack_n(tx_ack_n), .lp_sync(lp_sync));
   uald_dma_model #(.ACK_DLY(6)) u_rx (.clk(clk_sys), .rst_n(rst_n), .req_n(rx_req_n),
      .lp_req(lp_req), .ack_n(rx_ack_n), .lp_sync());
   // handshake build, tx request off until line control write
   uald_top #(.DMA_ACK_HANDSHAKE(1'b1), .TX_REQUEST_AT_RESET_PARAM(1'b0)) DUT_HS
      (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(), .PREADY(), .PSLVERR(), .TX_LEVEL(tx_level),
      .RX_LEVEL(rx_level), .RX_PUSH(rx_push), .RX_POP(rx_pop), .SIN(sin), .SIR_IN(sir_in),
      .SOUT(sout), .SIR_OUT_N(sir_out_n), .MODEM_IN(modem_in), .DMA_TX_ACK_N(hs_tx_ack_n),
      .DMA_RX_ACK_N(hs_rx_ack_n), .DMA_TX_REQ_N(hs_tx_req_n), .DMA_RX_REQ_N(hs_rx_req_n),
      .LOWPOWER_REQ_BUSCLK());
   uald_dma_model #(.ACK_DLY(1)) u_hs_tx (.clk(clk_sys), .rst_n(rst_n), .req_n(hs_tx_req_n),
      .lp_req(1'b0), .ack_n(hs_tx_ack_n), .lp_sync());
   uald_dma_model #(.ACK_DLY(2)) u_hs_rx (.clk(clk_sys), .rst_n(rst_n), .req_n(hs_rx_req_n),
      .lp_req(1'b0), .ack_n(hs_rx_ack_n), .lp_sync());

   // clock, reset and hang guard
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         results();
      end
   end

   task results();
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %b expected %b", $time, got, exp);
      end
   endtask

   // one apb transfer, waits for pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task step(input uald_level_type tl, input uald_level_type rl);
      tx_level <= tl;
      rx_level <= rl;
      repeat (4) @(posedge clk_sys);
   endtask

   task sleep(output int c);
      c = 0;
      while (lp_req !== 1'b1 && c < 200)
      begin
         @(posedge clk_sys);
         c++;
      end
   endtask

   // handshake build: request off while ack low, and some request seen
   task hs_walk();
      logic a1;
      logic a2;
      a1 = 1'b1;
      a2 = 1'b1;
      n = 0;
      t = 0;
      repeat (40)
      begin
         @(posedge clk_sys);
         if (!a1 && !a2)
         begin
            chk(hs_tx_req_n, 1'b1);
            t++;
         end
         n += !hs_tx_req_n;
         a2 = a1;
         a1 = hs_tx_ack_n;
      end
      chk(n > 0 && t > 0, 1'b1);
   endtask

   // transmit threshold decode
   function automatic uald_level_type tx_holding_reg(input logic [1:0] sel);
      case (sel)
         2'h0: return 5'h00;
         2'h1: return 5'h02;
         2'h2: return LVL_W'(FIFO_DEPTH / 4);
         default: return LVL_W'(FIFO_DEPTH / 2);
      endcase
   endfunction

   // main sequence
   initial
   begin
      void'($urandom(32'hd9c4));
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk(tx_req_n, 1'b0);
      chk(hs_tx_req_n, 1'b1);
      chk(rx_req_n, 1'b1);
      apb(1'b0, 8'h40, 32'h0);
      chk(er, 1'b1);
      for (int i = 0; i < 16; i++)
      begin
         s = 2'($urandom);
         m = 1'($urandom);
         t = $urandom % 17;
         r = $urandom % 17;
         apb(1'b1, OFS_FIFO_CTRL, {26'h0, s, 4'h1});
         apb(1'b1, OFS_MODE, {31'h0, m});
         step(LVL_W'(t), LVL_W'(r));
         chk(tx_req_n, m ? (t > tx_holding_reg(s)) : (t != 0));
         chk(rx_req_n, r == 0);
      end
      // empty both fifos: rx request drops, tx request stays asserted
      step(5'h00, 5'h00);
      apb(1'b1, OFS_MODE, 32'h0);
      apb(1'b1, OFS_FIFO_CTRL, 32'h49);
      for (int i = 0; i < 5; i++)
      begin
         step(txl[i], rxl[i]);
         chk(tx_req_n, txe[i]);
         chk(rx_req_n, rxe[i]);
      end
      rx_push <= 1'b1;
      @(posedge clk_sys);
      rx_push <= 1'b0;
      repeat (300) @(posedge clk_sys);
      rx_pop <= 1'b1;
      @(posedge clk_sys);
      rx_pop <= 1'b0;
      repeat (560) @(posedge clk_sys);
      chk(rx_req_n, 1'b1);
      repeat (140) @(posedge clk_sys);
      chk(rx_req_n, 1'b0);
      apb(1'b1, OFS_FIFO_CTRL, 32'h08);
      step(5'h00, 5'h01);
      chk(rx_req_n, 1'b0);
      step(5'h01, 5'h00);
      chk(tx_req_n, 1'b1);
      step(5'h00, 5'h00);
      chk(hs_tx_req_n, 1'b1);
      apb(1'b1, OFS_LINE_CTRL, 32'h0);
      sleep(n);
      chk(n > 100 && n < 125, 1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[0], 1'b1);
      chk(lp_req, 1'b1);
      chk(lp_sync, 1'b1);
      sin <= 1'b0;
      #1 chk(lp_req, 1'b0);
      @(posedge clk_sys);
      sin <= 1'b1;
      sleep(n);
      chk(lp_req, 1'b1);
      modem_in <= 4'h5;
      #1 chk(lp_req, 1'b0);
      sleep(n);
      chk(lp_req, 1'b1);
      apb(1'b1, OFS_DIVISOR, 32'h1);
      chk(lp_req, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, OFS_MODE, i == 0 ? 32'h2 : i == 1 ? 32'h4 : 32'h0);
         apb(1'b1, OFS_LINE_CTRL, i == 2 ? 32'h40 : 32'h0);
         sir_out_n <= (i == 3);
         sleep(n);
         chk(lp_req, 1'b0);
      end
      hs_walk();
      // soft reset: handshake build disarmed, default build armed
      apb(1'b1, OFS_SOFT_RESET, 32'h1);
      repeat (4) @(posedge clk_sys);
      chk(tx_req_n, 1'b0);
      chk(hs_tx_req_n, 1'b1);
      results();
   end
endmodule
